// ==== src/sdiag_pkg.sv ====
// package: frame layout, command codes and reply fields for the spi command block
`default_nettype none
package sdiag_pkg;
   localparam int unsigned FRAME_BITS   = 16;
   localparam int unsigned CHANNELS     = 10;
   localparam int unsigned CHECK_POS    = 15;
   // address field sits in bits 14:12, command group code in 11:8
   localparam logic [2:0]  ADDR_CMD     = 3'h0;
   localparam logic [2:0]  ADDR_DIAG    = 3'h1;
   localparam logic [3:0]  GRP_STATUS   = 4'h7;
   localparam logic [3:0]  SEL_SHORT    = 4'h1;
   localparam logic [3:0]  SEL_STATUS   = 4'h2;
   localparam logic [3:0]  SEL_PATTERN  = 4'h4;
   localparam logic [3:0]  SEL_INPUTS   = 4'h8;
   localparam int unsigned CLR_DEV_POS  = 4;
   localparam logic [3:0]  DG_READ_A    = 4'h5;
   localparam logic [3:0]  DG_READ_B    = 4'h6;
   localparam logic [3:0]  DG_CLEAR_A   = 4'h1;
   localparam logic [3:0]  DG_CLEAR_B   = 4'h2;
   localparam logic [3:0]  DG_MODE_CLR  = 4'h8;
   localparam logic [3:0]  DG_MODE_ONE  = 4'hB;
   localparam logic [3:0]  DG_MODE_TWO  = 4'hD;
   localparam logic [3:0]  DG_MODE_THR  = 4'hE;
   // device status bit positions
   localparam int unsigned ST_LOW_GRP   = 0;
   localparam int unsigned ST_HIGH_GRP  = 1;
   localparam int unsigned ST_UV_DIG    = 2;
   localparam int unsigned ST_UV_ANA    = 3;
   localparam int unsigned ST_MODULO    = 4;
   localparam int unsigned ST_COMM      = 5;
   localparam int unsigned LOW_GRP_LAST = 5;
   // idle times in ns and derived cycle counts at 50 MHz
   localparam int unsigned CLK_PERIOD_NS      = 20;
   localparam int unsigned DIAG_IDLE_NS       = 1000;
   localparam int unsigned OC_HOLD_NS         = 1000;
   localparam int unsigned DIAG_IDLE_CYC      = (DIAG_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned OC_HOLD_CYC        = (OC_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [15:0] WORD_RESET   = 16'h0000;
   typedef enum logic [1:0] {MODE_NONE, MODE_ONE, MODE_TWO, MODE_THREE} diag_mode_t;
   // one received command frame as split into fields
   typedef struct packed {
      logic       spare;
      logic [2:0] addr;
      logic [3:0] group;
      logic [7:0] data;
   } frame_t;
   // per-channel error inputs from the diagnosis circuit
   typedef struct packed {
      logic [CHANNELS-1:0] overcurrent;
      logic [CHANNELS-1:0] other;
   } chan_err_t;
endpackage : sdiag_pkg
`default_nettype wire

// ==== src/spi_shifter.sv ====
// spi shift engine: synchronises pins, shifts frames, flags frame start and end
`default_nettype none
module spi_shifter (
   input  wire logic        ref_clk_i,
   input  wire logic        sys_rst_i,
   input  wire logic        clk_en_i,
   input  wire logic        cs_n_i,
   input  wire logic        sck_i,
   input  wire logic        sdi_i,
   input  wire logic [15:0] tx_word_i,
   output logic             frame_start_o,
   output logic             frame_end_o,
   output logic [15:0]      rx_word_o,
   output logic             bit_count_ok_o,
   output logic             sdo_o
);
   // *************************************************
   // state
   // *************************************************
   typedef struct packed {
      logic [2:0]  cs_sync;
      logic [2:0]  sck_sync;
      logic [2:0]  sdi_sync;
      logic        cs_n;
      logic        sck;
      logic [15:0] rx;
      logic [15:0] tx;
      logic [4:0]  count;
      logic        start;
      logic        done;
      logic [15:0] rx_out;
      logic        ok;
   } shift_state_t;
   shift_state_t st_ff;
   shift_state_t nxt_st;

   // three-stage sync, change accepted once stages two and three agree
   always_comb begin
      nxt_st          = st_ff;
      nxt_st.cs_sync  = {st_ff.cs_sync[1:0], cs_n_i};
      nxt_st.sck_sync = {st_ff.sck_sync[1:0], sck_i};
      nxt_st.sdi_sync = {st_ff.sdi_sync[1:0], sdi_i};
      nxt_st.start    = 1'b0;
      nxt_st.done     = 1'b0;
      if (st_ff.cs_sync[2] == st_ff.cs_sync[1]) begin
         nxt_st.cs_n = st_ff.cs_sync[2];
      end
      if (st_ff.sck_sync[2] == st_ff.sck_sync[1]) begin
         nxt_st.sck = st_ff.sck_sync[2];
      end
      if (st_ff.cs_n && !nxt_st.cs_n) begin
         // frame opens: load reply, msb first
         nxt_st.start = 1'b1;
         nxt_st.tx    = tx_word_i;
         nxt_st.count = 5'h00;
      end else if (!st_ff.cs_n && nxt_st.cs_n) begin
         nxt_st.done   = 1'b1;
         nxt_st.rx_out = st_ff.rx;
         nxt_st.ok     = (st_ff.count == 5'h10);
      end else if (!st_ff.cs_n) begin
         if (!st_ff.sck && nxt_st.sck) begin
            // sample on rising clock edge
            nxt_st.rx = {st_ff.rx[14:0], st_ff.sdi_sync[2]};
            if (st_ff.count != 5'h1F) begin
               nxt_st.count = st_ff.count + 5'h01;
            end
         end else if (st_ff.sck && !nxt_st.sck) begin
            nxt_st.tx = {st_ff.tx[14:0], 1'b0};
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         st_ff <= '{cs_sync: 3'h7, sck_sync: 3'h0, sdi_sync: 3'h0, cs_n: 1'b1,
                    sck: 1'b0, rx: 16'h0000, tx: 16'h0000, count: 5'h00,
                    start: 1'b0, done: 1'b0, rx_out: 16'h0000, ok: 1'b0};
      end else if (clk_en_i) begin
         st_ff <= nxt_st;
      end
   end

   assign frame_start_o  = st_ff.start;
   assign frame_end_o    = st_ff.done;
   assign rx_word_o      = st_ff.rx_out;
   assign bit_count_ok_o = st_ff.ok;
   assign sdo_o          = st_ff.tx[15];
endmodule : spi_shifter
`default_nettype wire

// ==== src/spi_status_diag_command_feedback.sv ====
// top: command decode, diagnosis bank and reply capture for the spi side
`default_nettype none
// Operation
// - reply of a command frame is captured at its end, shifted next frame
// - short reply: one error bit per channel in 9:0, check bit 15
// - any register write makes the next reply the short diagnosis word
// - status reply uses bits 7:0, bits 6 and 7 always zero
// - status bit 0 set on any error in channels 1 to 6
// - status bit 1 set on any error in channels 7 to 10
// - status bits 2 and 3 follow digital and analogue undervoltage inputs
// - status bit 4 reports an earlier modulo counter error
// - status bit 5 reports an earlier rejected frame
// - pattern command returns its own pattern with check bit zero
// - input reply holds input levels sampled at chip select falling edge
// - undefined diagnosis group pattern is ignored and flagged as comm error
// - channel errors latch in the diagnosis bank until cleared
// - reading the bank leaves it unchanged
// - a clear empties its bank only after the idle time has passed
// - overcurrent entry resists clearing until its hold time passes
// - diagnosis reads and clears decoded from bits 11:8 with low byte zero
// - mode codes take low byte as output pin setting and select a mode
// - status commands: address 000, group 0111, one-hot selector
// - two selectors in one status frame are ignored and flagged; a clear bit with them still resets the modulo flag
module spi_status_diag_command_feedback (
   input  wire logic                  ref_clk_i,
   input  wire logic                  sys_rst_i,
   input  wire logic                  clk_en_i,
   input  wire logic                  cs_n_i,
   input  wire logic                  sck_i,
   input  wire logic                  sdi_i,
   input  wire logic [9:0]            direct_input_pins_i,
   input  wire sdiag_pkg::chan_err_t  chan_err_i,
   input  wire logic                  uv_digital_i,
   input  wire logic                  uv_analogue_i,
   input  wire logic                  modulo_err_i,
   input  wire logic                  reg_write_i,
   output logic                       sdo_o,
   output logic [7:0]                 output_pin_setting_o,
   output logic                       pin_setting_valid_o,
   output sdiag_pkg::diag_mode_t      diag_mode_o
);
   // *************************************************
   // state
   // *************************************************
   typedef struct packed {
      logic [15:0]           reply;
      logic [9:0]            err_a;
      logic [9:0]            err_b;
      logic [9:0]            oc_a;
      logic [9:0]            in_sync1;
      logic [9:0]            in_sync2;
      logic [9:0]            in_sync3;
      logic [9:0]            in_stable;
      logic [9:0]            in_snap;
      logic                  comm_err;
      logic                  mod_err;
      logic [7:0]            pins;
      logic                  pins_valid;
      sdiag_pkg::diag_mode_t mode;
      logic                  clr_a_pend;
      logic                  clr_b_pend;
      logic [7:0]            idle_cnt;
      logic [7:0]            oc_cnt;
   } top_state_t;
   top_state_t st_ff;
   top_state_t nxt_st;

   logic             frame_start;
   logic             frame_end;
   logic [15:0]      rx_word;
   logic             count_ok;
   logic             shift_sdo;
   sdiag_pkg::frame_t fr;

   // *************************************************
   // shift engine
   // *************************************************
   spi_shifter u_shift (
      .ref_clk_i      (ref_clk_i),
      .sys_rst_i      (sys_rst_i),
      .clk_en_i       (clk_en_i),
      .cs_n_i         (cs_n_i),
      .sck_i          (sck_i),
      .sdi_i          (sdi_i),
      .tx_word_i      (st_ff.reply),
      .frame_start_o  (frame_start),
      .frame_end_o    (frame_end),
      .rx_word_o      (rx_word),
      .bit_count_ok_o (count_ok),
      .sdo_o          (shift_sdo)
   );
   assign fr = sdiag_pkg::frame_t'(rx_word);

   // even parity over fifteen data bits
   function automatic logic [15:0] with_check(input logic [14:0] body);
      with_check = {^body, body};
   endfunction : with_check

   function automatic logic onehot4(input logic [3:0] v);
      onehot4 = (v != 4'h0) && ((v & (v - 4'h1)) == 4'h0);
   endfunction : onehot4

   // *************************************************
   // command decode and reply capture
   // *************************************************
   logic [9:0]  err_any;
   logic [7:0]  dev_flags;
   logic        is_status;
   logic        is_diag;
   logic [3:0]  sel;
   logic [14:0] body;
   logic        oc_hold;
   always_comb begin
      nxt_st = st_ff;
      // pin sync: three stages, accept once second and third agree
      nxt_st.in_sync1 = direct_input_pins_i;
      nxt_st.in_sync2 = st_ff.in_sync1;
      nxt_st.in_sync3 = st_ff.in_sync2;
      for (int i = 0; i < sdiag_pkg::CHANNELS; i++) begin
         if (st_ff.in_sync2[i] == st_ff.in_sync3[i]) begin
            nxt_st.in_stable[i] = st_ff.in_sync3[i];
         end
      end
      nxt_st.pins_valid = 1'b0;
      if (frame_start) begin
         nxt_st.in_snap = st_ff.in_stable;
      end
      // new errors latch; set wins over clear
      oc_hold = (st_ff.oc_cnt != 8'h00);
      if (st_ff.oc_cnt != 8'h00) begin
         nxt_st.oc_cnt = st_ff.oc_cnt - 8'h01;
      end
      if (st_ff.idle_cnt != 8'h00) begin
         nxt_st.idle_cnt = st_ff.idle_cnt - 8'h01;
      end else if (st_ff.clr_a_pend || st_ff.clr_b_pend) begin
         // clear lands only after idle time; overcurrent held until its hold ends
         if (st_ff.clr_a_pend && !oc_hold) begin
            nxt_st.err_a      = st_ff.oc_a & 10'h000;
            nxt_st.oc_a       = 10'h000;
            nxt_st.clr_a_pend = 1'b0;
         end else if (st_ff.clr_a_pend) begin
            nxt_st.err_a = st_ff.oc_a;
         end
         if (st_ff.clr_b_pend) begin
            nxt_st.err_b      = 10'h000;
            nxt_st.clr_b_pend = 1'b0;
         end
      end
      nxt_st.err_a = nxt_st.err_a | chan_err_i.overcurrent;
      nxt_st.oc_a  = nxt_st.oc_a | chan_err_i.overcurrent;
      nxt_st.err_b = nxt_st.err_b | chan_err_i.other;
      if (modulo_err_i) begin
         nxt_st.mod_err = 1'b1;
      end
      err_any   = st_ff.err_a | st_ff.err_b;
      dev_flags = 8'h00;
      dev_flags[sdiag_pkg::ST_LOW_GRP]  = |err_any[sdiag_pkg::LOW_GRP_LAST:0];
      dev_flags[sdiag_pkg::ST_HIGH_GRP] = |err_any[9:sdiag_pkg::LOW_GRP_LAST+1];
      dev_flags[sdiag_pkg::ST_UV_DIG]   = uv_digital_i;
      dev_flags[sdiag_pkg::ST_UV_ANA]   = uv_analogue_i;
      dev_flags[sdiag_pkg::ST_MODULO]   = st_ff.mod_err;
      dev_flags[sdiag_pkg::ST_COMM]     = st_ff.comm_err;
      is_status = (fr.addr == sdiag_pkg::ADDR_CMD) && (fr.group == sdiag_pkg::GRP_STATUS);
      is_diag   = (fr.addr == sdiag_pkg::ADDR_DIAG);
      sel       = fr.data[3:0];
      body      = 15'h0000;
      if (frame_end) begin
         // reply defaults to zero for unknown or ignored frames
         nxt_st.reply = sdiag_pkg::WORD_RESET;
         if (!count_ok) begin
            nxt_st.comm_err = 1'b1;
         end else if (is_status) begin
            if (fr.data[sdiag_pkg::CLR_DEV_POS] && !uv_digital_i && !uv_analogue_i) begin
               nxt_st.comm_err = 1'b0;
               nxt_st.mod_err  = modulo_err_i;
            end
            if (fr.data[7:5] != 3'h0) begin
               nxt_st.comm_err = 1'b1;
            end else if (sel != 4'h0 && !onehot4(sel)) begin
               nxt_st.comm_err = 1'b1;
            end else begin
               unique case (sel)
                  sdiag_pkg::SEL_SHORT: body = {5'h00, err_any};
                  sdiag_pkg::SEL_STATUS: body = {7'h00, dev_flags};
                  sdiag_pkg::SEL_PATTERN: body = rx_word[14:0];
                  sdiag_pkg::SEL_INPUTS: body = {5'h00, st_ff.in_snap};
                  default: body = 15'h0000;
               endcase
               if (sel == sdiag_pkg::SEL_PATTERN) begin
                  nxt_st.reply = {1'b0, body};
               end else if (sel != 4'h0) begin
                  nxt_st.reply = with_check(body);
               end
            end
         end else if (is_diag) begin
            unique case (fr.group)
               sdiag_pkg::DG_READ_A,
               sdiag_pkg::DG_READ_B,
               sdiag_pkg::DG_CLEAR_A,
               sdiag_pkg::DG_CLEAR_B: begin
                  if (fr.data != 8'h00) begin
                     nxt_st.comm_err = 1'b1;
                  end else begin
                     // reads never disturb bank contents
                     body = {5'h00, (fr.group == sdiag_pkg::DG_READ_A ||
                             fr.group == sdiag_pkg::DG_CLEAR_A) ? st_ff.err_a : st_ff.err_b};
                     nxt_st.reply = with_check(body);
                     if (fr.group == sdiag_pkg::DG_READ_A) begin
                        nxt_st.oc_cnt = 8'(sdiag_pkg::OC_HOLD_CYC);
                     end
                     if (fr.group == sdiag_pkg::DG_CLEAR_A) begin
                        nxt_st.clr_a_pend = 1'b1;
                        nxt_st.idle_cnt   = 8'(sdiag_pkg::DIAG_IDLE_CYC);
                     end
                     if (fr.group == sdiag_pkg::DG_CLEAR_B) begin
                        nxt_st.clr_b_pend = 1'b1;
                        nxt_st.idle_cnt   = 8'(sdiag_pkg::DIAG_IDLE_CYC);
                     end
                  end
               end
               sdiag_pkg::DG_MODE_CLR,
               sdiag_pkg::DG_MODE_ONE,
               sdiag_pkg::DG_MODE_TWO,
               sdiag_pkg::DG_MODE_THR: begin
                  nxt_st.pins       = fr.data;
                  nxt_st.pins_valid = 1'b1;
                  unique case (fr.group)
                     sdiag_pkg::DG_MODE_ONE: nxt_st.mode = sdiag_pkg::MODE_ONE;
                     sdiag_pkg::DG_MODE_TWO: nxt_st.mode = sdiag_pkg::MODE_TWO;
                     sdiag_pkg::DG_MODE_THR: nxt_st.mode = sdiag_pkg::MODE_THREE;
                     default: begin
                        nxt_st.mode       = sdiag_pkg::MODE_NONE;
                        nxt_st.clr_a_pend = 1'b1;
                        nxt_st.clr_b_pend = 1'b1;
                        nxt_st.idle_cnt   = 8'(sdiag_pkg::DIAG_IDLE_CYC);
                     end
                  endcase
                  nxt_st.reply = with_check({5'h00, err_any});
               end
               default: nxt_st.comm_err = 1'b1;
            endcase
         end else if (reg_write_i) begin
            // writes to other registers answer with the short word
            nxt_st.reply = with_check({5'h00, err_any});
         end
      end
   end

   // *************************************************
   // registers
   // *************************************************
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         st_ff <= '0;
      end else if (clk_en_i) begin
         st_ff <= nxt_st;
      end
   end

   // sdo already leaves the shift flop directly
   assign sdo_o                = shift_sdo;
   assign output_pin_setting_o = st_ff.pins;
   assign pin_setting_valid_o  = st_ff.pins_valid;
   assign diag_mode_o          = st_ff.mode;
endmodule : spi_status_diag_command_feedback
`default_nettype wire

// ==== dv/sdiag_properties.sv ====
// checker: port-level timing of the spi command block outputs
`default_nettype none
module sdiag_props (
   input  wire logic                  ref_clk_i,
   input  wire logic                  sys_rst_i,
   input  wire logic                  cs_n_i,
   input  wire logic                  sdo_o,
   input  wire logic [7:0]            output_pin_setting_o,
   input  wire logic                  pin_setting_valid_o,
   input  wire sdiag_pkg::diag_mode_t diag_mode_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // ************************************
   // assertions, single clock domain
   // ************************************
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (sys_rst_i);
   pulse_single_a : assert property (pin_setting_valid_o |=> !pin_setting_valid_o)
      else $error("pin setting strobe longer than one cycle");
   setting_hold_a : assert property (!$stable(output_pin_setting_o) |-> pin_setting_valid_o)
      else $error("pin setting moved without strobe");
   mode_hold_a : assert property (!$stable(diag_mode_o) |-> pin_setting_valid_o)
      else $error("diagnosis mode moved without strobe");
   taken_at_end_a : assert property (pin_setting_valid_o |-> cs_n_i)
      else $error("command acted on while chip select low");
   recent_frame_a : assert property (pin_setting_valid_o |-> !$past(cs_n_i, 7))
      else $error("strobe without a frame just before");
   frame_quiet_a : assert property ($fell(cs_n_i) |-> ##1 (!pin_setting_valid_o) [*8])
      else $error("strobe at start of a frame");
   // reset checks must run while reset is high, so no disable here
   reset_sdo_a : assert property (disable iff (1'b0) sys_rst_i |=> !sdo_o)
      else $error("serial out not low after reset");
   reset_pins_a : assert property (disable iff (1'b0) sys_rst_i |=>
      (output_pin_setting_o == 8'h00) && !pin_setting_valid_o
      && (diag_mode_o == sdiag_pkg::MODE_NONE))
      else $error("pin and mode outputs not cleared by reset");
endmodule : sdiag_props
bind spi_status_diag_command_feedback sdiag_props props (
   .ref_clk_i            (ref_clk_i),
   .sys_rst_i            (sys_rst_i),
   .cs_n_i               (cs_n_i),
   .sdo_o                (sdo_o),
   .output_pin_setting_o (output_pin_setting_o),
   .pin_setting_valid_o  (pin_setting_valid_o),
   .diag_mode_o          (diag_mode_o)
);
`default_nettype wire

// ==== dv/spi_host_model.sv ====
// partner: spi master driving chip select, clock and serial data
`default_nettype none
module spi_host_model (
   input  wire logic ref_clk_i,
   input  wire logic sdo_i,
   output var logic  cs_n_o,
   output var logic  sck_o,
   output var logic  sdi_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // ************************************
   // frame transfer, 160 ns link clock
   // ************************************
   initial begin
      cs_n_o = 1'b1;
      sck_o  = 1'b0;
      sdi_o  = 1'b0;
   end
   // sdo read at the edge where sck falls: device output has settled a full phase
   task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
      rx = 16'h0000;
      @(posedge ref_clk_i) cs_n_o <= 1'b0;
      repeat (10) @(posedge ref_clk_i);
      for (int i = n - 1; i >= 0; i--) begin
         sdi_o <= tx[i];
         repeat (4) @(posedge ref_clk_i);
         sck_o <= 1'b1;
         repeat (4) @(posedge ref_clk_i);
         rx[i] = sdo_i;
         sck_o <= 1'b0;
      end
      repeat (4) @(posedge ref_clk_i);
      cs_n_o <= 1'b1;
      sdi_o  <= ~tx[0]; // deselected line shows no stale bit
      repeat (12) @(posedge ref_clk_i);
   endtask : xfer
endmodule : spi_host_model
`default_nettype wire

// ==== dv/spi_status_diag_command_feedback_tb.sv ====
// testbench: random and corner frames through the spi command block
`default_nettype none
module spi_status_diag_command_feedback_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic                  clk, rst, cs_n, sck, sdi, sdo, uv_dig, uv_ana, mod_err, reg_wr, pin_vld;
   logic [9:0]            pins, pv, lat_a, lat_b;
   logic [7:0]            pin_set, d;
   logic [15:0]           rx;
   logic                  mod_f, comm_f, clk_en;
   sdiag_pkg::chan_err_t  err;
   sdiag_pkg::diag_mode_t mode;
   int                    bad_count, checks, cycles, i;
   int                    seed = 70652;
   logic [15:0]           bad [5] = '{16'h0703, 16'h1300, 16'h1501, 16'h070C, 16'h0702};
   int                    len [5] = '{16, 16, 16, 16, 15};
   logic [3:0]            codes [4] = '{sdiag_pkg::DG_MODE_CLR, sdiag_pkg::DG_MODE_ONE,
                                        sdiag_pkg::DG_MODE_TWO, sdiag_pkg::DG_MODE_THR};
   sdiag_pkg::diag_mode_t modes [4] = '{sdiag_pkg::MODE_NONE, sdiag_pkg::MODE_ONE,
                                        sdiag_pkg::MODE_TWO, sdiag_pkg::MODE_THREE};
   // ************************************
   // design, host model, clock
   // ************************************
   spi_status_diag_command_feedback dut (
      .ref_clk_i(clk), .sys_rst_i(rst), .clk_en_i(clk_en), .cs_n_i(cs_n), .sck_i(sck),
      .sdi_i(sdi), .direct_input_pins_i(pins), .chan_err_i(err), .uv_digital_i(uv_dig),
      .uv_analogue_i(uv_ana), .modulo_err_i(mod_err), .reg_write_i(reg_wr), .sdo_o(sdo),
      .output_pin_setting_o(pin_set), .pin_setting_valid_o(pin_vld), .diag_mode_o(mode));
   spi_host_model m (.ref_clk_i(clk), .sdo_i(sdo), .cs_n_o(cs_n), .sck_o(sck), .sdi_o(sdi));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // expected words: even check bit over the fifteen body bits
   function automatic logic [15:0] par(input logic [14:0] b);
      return {^b, b};
   endfunction : par
   function logic [15:0] sd_word();
      return par({5'h00, lat_a | lat_b});
   endfunction : sd_word
   function logic [15:0] st_word();
      return par({9'h000, comm_f, mod_f, uv_ana, uv_dig, |(lat_a[9:6] | lat_b[9:6]),
                  |(lat_a[5:0] | lat_b[5:0])});
   endfunction : st_word
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task end_of_test();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : end_of_test
   // whole run is some 70 frames of about 155 cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 60000) begin
         bad_count++;
         end_of_test();
      end
   end
   // ************************************
   // scenarios
   // ************************************
   initial begin
      rst = 1'b1; pins = '0; err = '0; uv_dig = 1'b0; uv_ana = 1'b0;
      mod_err = 1'b0; reg_wr = 1'b0; lat_a = '0; lat_b = '0; mod_f = 1'b0; comm_f = 1'b0;
      clk_en = 1'b1;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      repeat (6) @(posedge clk);
      m.xfer(16'h0710, 16, rx);
      m.xfer(16'h0704, 16, rx);
      m.xfer(16'h0700, 16, rx); check(rx, 16'h0704);
      for (i = 0; i < 8; i++) begin
         err <= $random(seed) & $random(seed) & $random(seed);
         {uv_dig, uv_ana} <= $random(seed);
         pins <= $random(seed);
         repeat (6) @(posedge clk);
         lat_a = lat_a | err.overcurrent;
         lat_b = lat_b | err.other;
         pv = pins;
         m.xfer(16'h0701, 16, rx);
         m.xfer(16'h0702, 16, rx); check(rx, sd_word());
         fork
            m.xfer(16'h0708, 16, rx);
            begin repeat (40) @(posedge clk); pins <= ~pv; end
         join
         check(rx, st_word());
         m.xfer(16'h0701, 16, rx); check(rx, par({5'h00, pv}));
      end
      // frozen block must not latch a modulo pulse that comes and goes meanwhile
      clk_en <= 1'b0;
      mod_err <= 1'b1;
      repeat (8) @(posedge clk);
      mod_err <= 1'b0;
      clk_en <= 1'b1;
      m.xfer(16'h0702, 16, rx);
      m.xfer(16'h0700, 16, rx); check(rx, st_word());
      // sticky modulo error shows in status until cleared
      mod_err <= 1'b1;
      repeat (8) @(posedge clk);
      mod_err <= 1'b0;
      mod_f = 1'b1;
      m.xfer(16'h0702, 16, rx);
      m.xfer(16'h0700, 16, rx); check(rx, st_word());
      mod_f = 1'b0;
      // status clear only works with both supplies good, so drop undervoltage first
      uv_dig <= 1'b0;
      uv_ana <= 1'b0;
      for (i = 0; i < 5; i++) begin
         m.xfer(16'h0710, 16, rx);
         m.xfer(bad[i], len[i], rx);
         m.xfer(16'h0702, 16, rx); check(rx, 16'h0000);
         comm_f = 1'b1;
         m.xfer(16'h0700, 16, rx); check(rx, st_word());
         comm_f = 1'b0;
      end
      // a write elsewhere turns the next reply into the short word
      m.xfer(16'h0704, 16, rx);
      reg_wr <= 1'b1;
      m.xfer(16'h2C00, 16, rx);
      reg_wr <= 1'b0;
      m.xfer(16'h0700, 16, rx); check(rx, sd_word());
      // errors gone at the pins, bank still holds them across reads
      err <= '0;
      m.xfer(16'h1500, 16, rx);
      m.xfer(16'h1600, 16, rx);
      m.xfer(16'h0701, 16, rx);
      m.xfer(16'h0700, 16, rx); check(rx, sd_word());
      m.xfer(16'h1100, 16, rx);
      m.xfer(16'h1200, 16, rx);
      repeat (60) @(posedge clk); // idle time after clear
      lat_a = '0;
      lat_b = '0;
      m.xfer(16'h0701, 16, rx);
      m.xfer(16'h0700, 16, rx); check(rx, sd_word());
      for (i = 0; i < 4; i++) begin
         d = $random(seed);
         m.xfer({4'h1, codes[i], d}, 16, rx);
         check({8'h00, pin_set}, {8'h00, d});
         check({14'h0000, mode}, {14'h0000, modes[i]});
      end
      end_of_test();
   end
endmodule : spi_status_diag_command_feedback_tb
`default_nettype wire
